// ---- rtl/smcr_pkg.sv ----
// constants, types and carriers for the sensor mode configuration registers
// Operation
// [RULE1] A three-bit operating-mode field at bits 6-4 picks configuration, standby, continuous, triggered, duty-cycled, sleep or deep sleep (codes 0 to 6).
// [RULE2] Writing the unused mode code 7 stores code 0, so the device enters configuration mode.
// [RULE3] A trigger request is passed on only in configuration, standby or triggered mode.
// [RULE4] In deep sleep the device wakes as soon as the SPI host pulls chip select low.
// [RULE5] Bit 3 turns temperature conversion on; when clear no temperature conversion is made (the code still makes one when bit 0 is set).
// [RULE6] Bit 2 clear makes temperature follow the averaging count; set makes one temperature conversion per set.
// [RULE7] Bit 1 switches the temperature limit check on when set and off when clear.
// [RULE8] Bit 0 requests one temperature conversion per wake-up cycle and per set for compensation.
// [RULE9] Bits 15-14 of the sensor channel register pick no angle, X-Y, Y-Z or Z-X angle.
// [RULE10] After reset every field reads zero: configuration mode, all temperature and angle features off.
// [RULE11] A three-bit averaging field at bits 14-12 gives 1x to 32x for codes 0 to 5; codes 6 and 7 store 0.
// [RULE12] A written value takes effect only after its write frame has ended and never during a conversion.
`default_nettype none

package smcr_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [6:0]  DEV_CFG_OFS   = 7'h00;
  localparam logic [6:0]  SEN_CFG_OFS   = 7'h01;
  localparam logic [15:0] DEV_CFG_RST   = 16'h0000;
  localparam logic [15:0] SEN_CFG_RST   = 16'h0000;
  localparam logic [15:0] DEV_CFG_MASK  = 16'h737f;
  localparam logic [15:0] SEN_CFG_MASK  = 16'hffff;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int AVG_MSB       = 14;
  localparam int AVG_LSB       = 12;
  localparam int TEMPCO_MSB    = 9;
  localparam int TEMPCO_LSB    = 8;
  localparam int MODE_MSB      = 6;
  localparam int MODE_LSB      = 4;
  localparam int TEMP_EN_BIT   = 3;
  localparam int TEMP_RATE_BIT = 2;
  localparam int TEMP_LIM_BIT  = 1;
  localparam int TEMP_COMP_BIT = 0;
  localparam int ANGLE_MSB     = 15;
  localparam int ANGLE_LSB     = 14;

  localparam logic [2:0] AVG_MAX     = 3'h5;
  localparam logic [2:0] AVG_DEFAULT = 3'h0;

  // ----------------------------------------
  // spi frame bit counts
  // ----------------------------------------
  localparam logic [4:0] FRM_HDR_LAST   = 5'h07;
  localparam logic [4:0] FRM_DATA_FIRST = 5'h08;
  localparam logic [4:0] FRM_DATA_LAST  = 5'h17;
  localparam logic [4:0] FRM_LAST       = 5'h1f;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_CONFIG,
    MODE_STANDBY,
    MODE_CONTINUOUS,
    MODE_TRIGGERED,
    MODE_DUTY_CYCLE,
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_UNUSED
  } smcr_mode_type;

  typedef enum logic [1:0] {
    ANGLE_NONE,
    ANGLE_XY,
    ANGLE_YZ,
    ANGLE_ZX
  } smcr_angle_type;

  typedef struct packed {
    smcr_mode_type  mode;
    logic           temp_channel_enable;
    logic           temp_rate_once;
    logic           temp_limit_check_enable;
    logic           temp_comp_enable;
    logic [2:0]     sample_averaging;
    logic [1:0]     magnet_tempco;
    smcr_angle_type angle;
  } smcr_cfg_type;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
  } smcr_wr_type;

  localparam smcr_cfg_type CFG_RST = '{
    mode:                    MODE_CONFIG,
    temp_channel_enable:     1'b0,
    temp_rate_once:          1'b0,
    temp_limit_check_enable: 1'b0,
    temp_comp_enable:        1'b0,
    sample_averaging:        3'h0,
    magnet_tempco:           2'h0,
    angle:                   ANGLE_NONE
  };

endpackage

`default_nettype wire

// ---- rtl/smcr_sync.sv ----
// two flip-flop synchroniser for levels entering the main clock domain
`default_nettype none

module smcr_sync #(
  parameter int W       = 1,
  parameter bit RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= {W{RST_VAL}};
      q_o    <= {W{RST_VAL}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/smcr_regs.sv ----
// sensor mode configuration registers with spi frame access
`default_nettype none

module smcr_regs (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // spi link
  input  wire logic                  spi_sclk_i,
  input  wire logic                  spi_cs_n_i,
  input  wire logic                  spi_mosi_i,
  output var  logic                  spi_miso_o,
  // sequencer side
  input  wire logic                  conv_busy_i,
  input  wire logic                  trig_req_i,
  output var  smcr_pkg::smcr_cfg_type cfg_o,
  output var  logic [5:0]            temp_conv_count_o,
  output var  logic                  trig_o,
  output var  logic                  wake_o,
  output var  logic                  deep_sleep_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                   frame_rst;
  logic [4:0]             cnt_r;
  logic [4:0]             cnt_nxt;
  logic [30:0]            rx_r;
  logic [30:0]            rx_nxt;
  logic [15:0]            rd_r;
  logic [15:0]            rd_nxt;
  logic [7:0]             hdr_w;
  logic [31:0]            word_w;
  smcr_pkg::smcr_wr_type  wr_r;
  smcr_pkg::smcr_wr_type  wr_nxt;
  logic                   tgl_r;
  logic                   tgl_nxt;
  logic                   miso_nxt;
  logic                   cs_s;
  logic                   tgl_s;
  logic                   tgl_seen_r;
  logic                   tgl_seen_nxt;
  logic                   pend_r;
  logic                   pend_nxt;
  logic                   apply;
  logic [15:0]            dev_reg_r;
  logic [15:0]            dev_reg_nxt;
  logic [15:0]            sen_reg_r;
  logic [15:0]            sen_reg_nxt;
  smcr_pkg::smcr_cfg_type cfg_nxt;
  logic [5:0]             tcnt_nxt;
  logic                   woken_r;
  logic                   woken_nxt;
  logic                   wake_nxt;
  logic                   deep_nxt;
  logic                   trig_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] readback(input logic [6:0]  a,
                                           input logic [15:0] d,
                                           input logic [15:0] s);
    logic [15:0] v;
    v = 16'h0000;
    if (a == smcr_pkg::DEV_CFG_OFS) begin
      v = d & smcr_pkg::DEV_CFG_MASK;
    end else if (a == smcr_pkg::SEN_CFG_OFS) begin
      v = s & smcr_pkg::SEN_CFG_MASK;
    end
    return v;
  endfunction

  function automatic logic mode_takes_trig(input smcr_pkg::smcr_mode_type m);
    return (m == smcr_pkg::MODE_CONFIG) || (m == smcr_pkg::MODE_STANDBY) ||
           (m == smcr_pkg::MODE_TRIGGERED);
  endfunction

  // ----------------------------------------
  // link domain: frame shift and readback
  // ----------------------------------------
  assign frame_rst = rst_i | spi_cs_n_i;
  assign hdr_w     = {rx_r[6:0], spi_mosi_i};
  assign word_w    = {rx_r, spi_mosi_i};

  always_comb begin
    cnt_nxt = cnt_r + 5'h01;
    rx_nxt  = {rx_r[29:0], spi_mosi_i};
    rd_nxt  = rd_r;
    if (cnt_r == smcr_pkg::FRM_HDR_LAST) begin
      // registers only change while chip select is high, so they are still here
      rd_nxt = hdr_w[7] ? readback(hdr_w[6:0], dev_reg_r, sen_reg_r) : 16'h0000;
    end
  end

  always_ff @(posedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_r <= 5'h00;
      rx_r  <= 31'h0000_0000;
      rd_r  <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
      rx_r  <= rx_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // capture of a complete write frame
  always_comb begin
    wr_nxt  = wr_r;
    tgl_nxt = tgl_r;
    if ((cnt_r == smcr_pkg::FRM_LAST) && !word_w[31]) begin
      wr_nxt.addr = word_w[30:24];
      wr_nxt.data = word_w[23:8];
      tgl_nxt     = ~tgl_r;
    end
  end

  always_ff @(posedge spi_sclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r  <= '0;
      tgl_r <= 1'b0;
    end else begin
      wr_r  <= wr_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  // miso launch on the falling edge
  always_comb begin
    miso_nxt = 1'b0;
    if ((cnt_r >= smcr_pkg::FRM_DATA_FIRST) && (cnt_r <= smcr_pkg::FRM_DATA_LAST)) begin
      miso_nxt = rd_r[4'(smcr_pkg::FRM_DATA_LAST - cnt_r)];
    end
  end

  always_ff @(negedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      spi_miso_o <= 1'b0;
    end else begin
      spi_miso_o <= miso_nxt;
    end
  end

  // ----------------------------------------
  // crossings into the main domain
  // ----------------------------------------
  smcr_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .d_i   (spi_cs_n_i),
    .q_o   (cs_s)
  );

  smcr_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .d_i   (tgl_r),
    .q_o   (tgl_s)
  );

  // ----------------------------------------
  // main domain: register update and config
  // ----------------------------------------
  always_comb begin
    tgl_seen_nxt = tgl_s;
    apply        = pend_r & cs_s;
    pend_nxt     = (tgl_s ^ tgl_seen_r) | (pend_r & ~cs_s);  // RULE12
    dev_reg_nxt  = dev_reg_r;
    sen_reg_nxt  = sen_reg_r;
    if (apply && (wr_r.addr == smcr_pkg::DEV_CFG_OFS)) begin
      dev_reg_nxt = wr_r.data & smcr_pkg::DEV_CFG_MASK;
      if (wr_r.data[smcr_pkg::MODE_MSB:smcr_pkg::MODE_LSB] == smcr_pkg::MODE_UNUSED) begin
        dev_reg_nxt[smcr_pkg::MODE_MSB:smcr_pkg::MODE_LSB] = smcr_pkg::MODE_CONFIG;  // RULE2
      end
      if (wr_r.data[smcr_pkg::AVG_MSB:smcr_pkg::AVG_LSB] > smcr_pkg::AVG_MAX) begin
        dev_reg_nxt[smcr_pkg::AVG_MSB:smcr_pkg::AVG_LSB] = smcr_pkg::AVG_DEFAULT;  // RULE11
      end
    end
    if (apply && (wr_r.addr == smcr_pkg::SEN_CFG_OFS)) begin
      sen_reg_nxt = wr_r.data & smcr_pkg::SEN_CFG_MASK;
    end
  end

  always_comb begin
    cfg_nxt = cfg_o;
    if (!conv_busy_i) begin  // RULE12
      cfg_nxt.mode = smcr_pkg::smcr_mode_type'(
        dev_reg_r[smcr_pkg::MODE_MSB:smcr_pkg::MODE_LSB]);  // RULE1
      cfg_nxt.temp_channel_enable     = dev_reg_r[smcr_pkg::TEMP_EN_BIT];  // RULE5
      cfg_nxt.temp_rate_once          = dev_reg_r[smcr_pkg::TEMP_RATE_BIT];  // RULE6
      cfg_nxt.temp_limit_check_enable = dev_reg_r[smcr_pkg::TEMP_LIM_BIT];  // RULE7
      cfg_nxt.temp_comp_enable        = dev_reg_r[smcr_pkg::TEMP_COMP_BIT];  // RULE8
      cfg_nxt.sample_averaging = dev_reg_r[smcr_pkg::AVG_MSB:smcr_pkg::AVG_LSB];  // RULE11
      cfg_nxt.magnet_tempco    = dev_reg_r[smcr_pkg::TEMPCO_MSB:smcr_pkg::TEMPCO_LSB];
      cfg_nxt.angle = smcr_pkg::smcr_angle_type'(
        sen_reg_r[smcr_pkg::ANGLE_MSB:smcr_pkg::ANGLE_LSB]);  // RULE9
    end
    // temperature conversions per set
    if (!cfg_nxt.temp_channel_enable && !cfg_nxt.temp_comp_enable) begin
      tcnt_nxt = 6'h00;  // RULE5
    end else if (cfg_nxt.temp_rate_once || !cfg_nxt.temp_channel_enable) begin
      tcnt_nxt = 6'h01;  // RULE6 RULE8
    end else begin
      tcnt_nxt = 6'h01 << cfg_nxt.sample_averaging;  // RULE6
    end
  end

  // deep sleep wake and trigger gating
  always_comb begin
    woken_nxt = woken_r;
    wake_nxt  = 1'b0;
    if (cfg_o.mode != smcr_pkg::MODE_DEEP_SLEEP) begin
      woken_nxt = 1'b0;
    end else if (!cs_s) begin
      woken_nxt = 1'b1;  // RULE4
      wake_nxt  = ~woken_r;  // RULE4
    end
    deep_nxt = (cfg_o.mode == smcr_pkg::MODE_DEEP_SLEEP) & ~woken_nxt;
    trig_nxt = trig_req_i & mode_takes_trig(cfg_o.mode);  // RULE3
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_seen_r        <= 1'b0;
      pend_r            <= 1'b0;
      dev_reg_r         <= smcr_pkg::DEV_CFG_RST;  // RULE10
      sen_reg_r         <= smcr_pkg::SEN_CFG_RST;  // RULE10
      cfg_o             <= smcr_pkg::CFG_RST;  // RULE10
      temp_conv_count_o <= 6'h00;
      woken_r           <= 1'b0;
      wake_o            <= 1'b0;
      deep_sleep_o      <= 1'b0;
      trig_o            <= 1'b0;
    end else begin
      tgl_seen_r        <= tgl_seen_nxt;
      pend_r            <= pend_nxt;
      dev_reg_r         <= dev_reg_nxt;
      sen_reg_r         <= sen_reg_nxt;
      cfg_o             <= cfg_nxt;
      temp_conv_count_o <= tcnt_nxt;
      woken_r           <= woken_nxt;
      wake_o            <= wake_nxt;
      deep_sleep_o      <= deep_nxt;
      trig_o            <= trig_nxt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb_main @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_cs_in_deep;
    (cfg_o.mode == smcr_pkg::MODE_DEEP_SLEEP) && !woken_r && !cs_s;
  endsequence

  sequence seq_wake_seen;
    (wake_o && !deep_sleep_o) ##1 !wake_o;
  endsequence

  sequence seq_unused_mode_write;
    apply && (wr_r.addr == smcr_pkg::DEV_CFG_OFS) &&
      (wr_r.data[smcr_pkg::MODE_MSB:smcr_pkg::MODE_LSB] == 3'h7);
  endsequence

  AST_DEEP_FLAG: assert property (  // RULE1
    deep_sleep_o |-> $past(cfg_o.mode) == smcr_pkg::MODE_DEEP_SLEEP)
    else $error("deep sleep flag without deep sleep mode");

  AST_UNUSED_MODE: assert property (  // RULE2
    seq_unused_mode_write |=> (dev_reg_r[smcr_pkg::MODE_MSB:smcr_pkg::MODE_LSB] == 3'h0))
    else $error("unused mode code not turned into configuration mode");

  AST_TRIG_GATE: assert property (  // RULE3
    trig_o |-> $past(trig_req_i) && mode_takes_trig($past(cfg_o.mode)))
    else $error("trigger passed in a mode that ignores it");

  AST_DEEP_WAKE: assert property (  // RULE4
    seq_cs_in_deep |=> seq_wake_seen)
    else $error("chip select did not wake the device from deep sleep");

  AST_TEMP_OFF: assert property (  // RULE5
    (!cfg_o.temp_channel_enable && !cfg_o.temp_comp_enable) |-> temp_conv_count_o == 6'h00)
    else $error("temperature converted while disabled");

  AST_TEMP_RATE: assert property (  // RULE6
    (cfg_o.temp_channel_enable && !cfg_o.temp_rate_once) |->
      temp_conv_count_o == (6'h01 << cfg_o.sample_averaging))
    else $error("temperature count does not follow averaging");

  AST_LIMIT_FOLLOW: assert property (  // RULE7
    $past(!conv_busy_i) |->
      cfg_o.temp_limit_check_enable == $past(dev_reg_r[smcr_pkg::TEMP_LIM_BIT]))
    else $error("limit check enable does not follow its bit");

  AST_COMP_ONCE: assert property (  // RULE8
    (cfg_o.temp_comp_enable && (!cfg_o.temp_channel_enable || cfg_o.temp_rate_once)) |->
      temp_conv_count_o == 6'h01)
    else $error("compensation does not take one temperature conversion");

  AST_ANGLE_SEL: assert property (  // RULE9
    $past(!conv_busy_i) |->
      cfg_o.angle == $past(sen_reg_r[smcr_pkg::ANGLE_MSB:smcr_pkg::ANGLE_LSB]))
    else $error("angle selection does not follow its field");

  AST_AVG_RANGE: assert property (  // RULE11
    cfg_o.sample_averaging <= smcr_pkg::AVG_MAX)
    else $error("averaging code out of range");

  AST_HOLD_BUSY: assert property (  // RULE12
    $past(conv_busy_i) |-> $stable(cfg_o))
    else $error("configuration changed during a conversion");

  AST_APPLY_AFTER_FRAME: assert property (  // RULE12
    ($changed(dev_reg_r) || $changed(sen_reg_r)) |-> $past(pend_r && cs_s))
    else $error("register changed before the frame ended");

endmodule

`default_nettype wire

// ---- tb/smcr_host_model.sv ----
// spi host model issuing 32-bit mode 0 frames
`default_nettype none

module smcr_host_model (
  // spi link
  output var  logic spi_sclk_o,
  output var  logic spi_cs_n_o,
  output var  logic spi_mosi_o,
  input  wire logic spi_miso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time HALF = 16ns;

  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // ----------------------------------------
  // one whole frame, msb first
  // ----------------------------------------
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx, input int tail);
    rx = 32'h0000_0000;
    #7;
    spi_cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi_o = tx[i];
      #(HALF);
      rx[i] = spi_miso_i;
      spi_sclk_o = 1'b1;
      #(HALF);
      spi_sclk_o = 1'b0;
    end
    // chip select held low for tail half periods after the last clock
    #(HALF * tail);
    spi_cs_n_o = 1'b1;
    // released line no longer shows its last level
    spi_mosi_o = ~spi_mosi_o;
  endtask
endmodule

`default_nettype wire

// ---- tb/sensor_mode_config_regs_test.sv ----
// self-checking bench for the sensor mode configuration registers
`default_nettype none

module sensor_mode_config_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
    logic [15:0] rd;
  } smcr_row_type;

  logic                   mclk      = 1'b0;
  logic                   rst       = 1'b1;
  logic                   conv_busy = 1'b0;
  logic                   trig_req  = 1'b0;
  wire logic              sclk;
  wire logic              cs_n;
  wire logic              mosi;
  logic                   miso;
  smcr_pkg::smcr_cfg_type cfg;
  logic [5:0]             cnt;
  logic                   trig;
  logic                   wake;
  logic                   deep;
  logic [31:0]            rx;
  logic [15:0]            rdv;
  logic [15:0]            dev_s     = 16'h0000;
  logic [15:0]            sen_s     = 16'h0000;
  logic [7:0]             wakes     = 8'h00;
  logic [7:0]             w0;
  int                     mismatches  = 0;
  int                     comparisons = 0;

  smcr_row_type rows [15] = '{
    '{7'h01, 16'h4000, 16'h4000}, '{7'h00, 16'h0008, 16'h0008},
    '{7'h00, 16'h500c, 16'h500c}, '{7'h00, 16'h5008, 16'h5008},
    '{7'h00, 16'h3018, 16'h3018}, '{7'h01, 16'h8000, 16'h8000},
    '{7'h00, 16'h0021, 16'h0021}, '{7'h00, 16'h0032, 16'h0032},
    '{7'h00, 16'h0040, 16'h0040}, '{7'h00, 16'h0050, 16'h0050},
    '{7'h00, 16'h6070, 16'h0000}, '{7'h00, 16'h7fff, 16'h030f},
    '{7'h00, 16'h8a80, 16'h0200}, '{7'h05, 16'hffff, 16'h0000},
    '{7'h01, 16'hc000, 16'hc000}
  };

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (wake === 1'b1) begin
      wakes <= wakes + 8'h01;
    end
  end

  smcr_regs dut (
    .mclk_i            (mclk),
    .rst_i             (rst),
    .spi_sclk_i        (sclk),
    .spi_cs_n_i        (cs_n),
    .spi_mosi_i        (mosi),
    .spi_miso_o        (miso),
    .conv_busy_i       (conv_busy),
    .trig_req_i        (trig_req),
    .cfg_o             (cfg),
    .temp_conv_count_o (cnt),
    .trig_o            (trig),
    .wake_o            (wake),
    .deep_sleep_o      (deep)
  );

  smcr_host_model host (
    .spi_sclk_o (sclk),
    .spi_cs_n_o (cs_n),
    .spi_mosi_o (mosi),
    .spi_miso_i (miso)
  );

  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  function automatic smcr_pkg::smcr_cfg_type exp_cfg(input logic [15:0] d,
                                                     input logic [15:0] s);
    smcr_pkg::smcr_cfg_type c;
    c.mode                    = smcr_pkg::smcr_mode_type'(d[6:4]);
    c.temp_channel_enable     = d[3];
    c.temp_rate_once          = d[2];
    c.temp_limit_check_enable = d[1];
    c.temp_comp_enable        = d[0];
    c.sample_averaging        = d[14:12];
    c.magnet_tempco           = d[9:8];
    c.angle                   = smcr_pkg::smcr_angle_type'(s[15:14]);
    return c;
  endfunction

  function automatic logic [5:0] exp_cnt(input logic [15:0] d);
    if (d[3]) begin
      return d[2] ? 6'h01 : (6'h01 << d[14:12]);
    end
    return {5'h00, d[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic gap();
    repeat (12) @(posedge mclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.frame({1'b0, a, d, 8'h00}, rx, 1);
    check(rx, 32'h0000_0000, "write frame miso");
    gap();
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    host.frame({1'b1, a, 16'h0000, 8'h00}, rx, 1);
    d = rx[23:8];
    gap();
  endtask

  task automatic trig_chk(input logic exp);
    @(posedge mclk);
    trig_req <= 1'b1;
    @(posedge mclk);
    trig_req <= 1'b0;
    #1;
    check(32'(trig), 32'(exp), "trigger pass");
  endtask

  task automatic chk_reset(input string what);
    check(32'(cfg), 32'(smcr_pkg::CFG_RST), what);
    check(32'(cnt), 32'h0, what);
    check(32'(deep), 32'h0, what);
    rd(7'h00, rdv);
    check(32'(rdv), 32'h0, what);
    rd(7'h01, rdv);
    check(32'(rdv), 32'h0, what);
    $display("test %s done", what);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_reset("reset state");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      if (rows[i].addr == 7'h00) begin
        dev_s = rows[i].rd;
      end
      if (rows[i].addr == 7'h01) begin
        sen_s = rows[i].rd;
      end
      rd(rows[i].addr, rdv);
      check(32'(rdv), 32'(rows[i].rd), "readback");
      check(32'(cfg), 32'(exp_cfg(dev_s, sen_s)), "cfg out");
      check(32'(cnt), 32'(exp_cnt(dev_s)), "temp count");
      trig_chk(dev_s[6:4] inside {3'h0, 3'h1, 3'h3});
    end
    $display("test table rows done");
    @(posedge mclk);
    conv_busy <= 1'b1;
    wr(7'h00, 16'h0018);
    rd(7'h00, rdv);
    check(32'(rdv), 32'h0018, "register while busy");
    check(32'(cfg), 32'(exp_cfg(dev_s, sen_s)), "cfg frozen");
    @(posedge mclk);
    conv_busy <= 1'b0;
    repeat (3) @(posedge mclk);
    dev_s = 16'h0018;
    check(32'(cfg), 32'(exp_cfg(dev_s, sen_s)), "cfg after busy");
    fork
      host.frame({1'b0, 7'h00, 16'h0021, 8'h00}, rx, 8);
    join_none
    #1095;
    check(32'(cfg), 32'(exp_cfg(dev_s, sen_s)), "cfg mid frame");
    wait (cs_n === 1'b1);
    gap();
    dev_s = 16'h0021;
    check(32'(cfg), 32'(exp_cfg(dev_s, sen_s)), "cfg after frame");
    $display("test hold until applied done");
    wr(7'h00, 16'h0060);
    dev_s = 16'h0060;
    check(32'(deep), 32'h1, "deep sleep entered");
    trig_chk(1'b0);
    w0 = wakes;
    rd(7'h00, rdv);
    check(32'(wakes - w0), 32'h1, "wake pulses");
    check(32'(deep), 32'h0, "woken");
    check(32'(rdv), 32'h0060, "mode kept");
    $display("test deep sleep wake done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_reset("mid-run reset");
    test_done();
  end

  initial begin
    #400us;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule

`default_nettype wire
